// *** common/psmc_pkg.sv ***
// constants and types shared by the power saving mode controller
package psmc_pkg;
  localparam logic [7:0] PSMC_HALT_OPCODE = 8'h8e;
  localparam int PSMC_SLOW_DIV = 32;
  localparam int PSMC_STAB_CYCLES = 256;
  localparam int PSMC_CNT_W = 16;
  // register map, byte offsets
  localparam logic [7:0] PSMC_REG_CTRL = 8'h00;
  localparam logic [7:0] PSMC_REG_STATUS = 8'h04;
  // control register fields
  localparam int PSMC_CTRL_SLOW_BIT = 0;
  localparam int PSMC_CTRL_WDGH_BIT = 1;
  localparam int PSMC_CTRL_PLL_BIT = 2;
  localparam logic [2:0] PSMC_CTRL_RST = 3'h0;
  // status register fields
  localparam int PSMC_STAT_AHSEL_BIT = 3;
  localparam int PSMC_STAT_WDG_BIT = 4;
  // mode codes shown in the status register
  localparam logic [2:0] PSMC_MODE_RUN = 3'h0;
  localparam logic [2:0] PSMC_MODE_SLOW = 3'h1;
  localparam logic [2:0] PSMC_MODE_WAIT = 3'h2;
  localparam logic [2:0] PSMC_MODE_SLOW_WAIT = 3'h3;
  localparam logic [2:0] PSMC_MODE_AHALT = 3'h4;
  localparam logic [2:0] PSMC_MODE_HALT = 3'h5;
  localparam logic [2:0] PSMC_MODE_STAB = 3'h6;

  typedef enum logic [2:0] {
    ST_RUN, ST_SLOW, ST_WAIT, ST_SLOW_WAIT, ST_AHALT, ST_HALT, ST_STAB
  } psmc_state_e;

  // wake-up timer configuration seen by the halt decision
  typedef struct packed {
    logic timebase_irq_enable;
    logic overflow_irq_enable;
    logic timer_clock_select_hi;
    logic timer_clock_select_lo;
  } psmc_tmr_cfg_s;

  // wake sources from the interrupt and reset logic
  typedef struct packed {
    logic irq_pending;
    logic irq_halt_wake;
    logic irq_timer_wake;
    logic reset_req;
  } psmc_wake_s;
endpackage

// *** rtl/psmc_ctrl.sv ***
// power saving mode controller: run, slow, wait, active-halt and halt
//
// Overview of operation
// RULE_01: any reset starts in run, full clock
// RULE_02: slow select divides cpu clock by 32
// RULE_03: wait while slow gives slow-wait state
// RULE_04: lite timer clock always oscillator over 32
// RULE_05: wait stops cpu, peripherals keep running
// RULE_06: wait entry clears interrupt mask
// RULE_07: wait ends on interrupt or reset
// RULE_08: service pushes condition codes, masks interrupts
// RULE_09: halt picks active-halt from timer enables
// RULE_10: active-halt wakes on timer irq or reset
// RULE_11: reset from active-halt waits 256 cycles
// RULE_12: timer irq leaves active-halt without delay
// RULE_13: active-halt entry clears mask, pending wakes
// RULE_14: active-halt clocks only oscillator, wake timer
// RULE_15: active-halt, option clear: no watchdog reset
// RULE_16: full halt switches oscillator off
// RULE_17: halt wake restarts oscillator, 256-cycle delay
// RULE_18: halt entry forces mask clear, pending wakes
// RULE_19: halt with watchdog: reset or halt
// RULE_20: pll clock only after its startup delay; code waits only in the stabilisation count, a control write enables it at once
// RULE_21: opcode 8e decodes as halt
// RULE_22: state machine, every reset returns run
// RULE_23: option set resets, clear enters halt
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module psmc_ctrl
  import psmc_pkg::*;
#(
  parameter int PLL_STAB_CYCLES = 64
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic wait_instr_in,
  input wire psmc_tmr_cfg_s tmr_cfg_in,
  input wire psmc_wake_s wake_in,
  input wire logic wdg_enabled_in,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic lite_timer_clk_en_out,
  output logic autoreload_timer_clk_en_out,
  output logic osc_en_out,
  output logic pll_clk_en_out,
  output logic imask_clear_out,
  output logic irq_service_out,
  output logic reset_fetch_out,
  output logic wdg_reset_out
);

  localparam logic [4:0] DIV_LAST = 5'(PSMC_SLOW_DIV - 1);
  localparam logic [PSMC_CNT_W-1:0] STAB_BASE =
    PSMC_CNT_W'(PSMC_STAB_CYCLES);
  localparam logic [PSMC_CNT_W-1:0] STAB_PLL =
    PSMC_CNT_W'(PSMC_STAB_CYCLES + PLL_STAB_CYCLES);

  logic rst_meta_r;
  logic rst_n_r;
  psmc_state_e state_r;
  psmc_state_e state_nxt;
  logic [2:0] ctrl_r;
  logic [4:0] div_cnt_r;
  logic [PSMC_CNT_W-1:0] stab_cnt_r;
  logic [PSMC_CNT_W-1:0] stab_len_r;
  logic stab_is_reset_r;
  logic [7:0] rd_data_r;
  logic svc_nxt;
  logic fetch_nxt;
  logic wdg_rst_nxt;
  logic halt_exec;
  logic ahalt_sel;
  logic slow_sel;
  logic div_last;
  logic enter_stab;
  logic asleep_nxt;
  logic asleep_r;
  logic [2:0] mode_code;

  // asynchronous assert, synchronous release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  assign slow_sel = ctrl_r[PSMC_CTRL_SLOW_BIT];
  assign halt_exec = opcode_valid_in &&
                     (opcode_in == PSMC_HALT_OPCODE); // RULE_21
  // table: lite timebase enable, or autoreload overflow with select 01
  assign ahalt_sel = tmr_cfg_in.timebase_irq_enable |
                     (tmr_cfg_in.overflow_irq_enable &
                      ~tmr_cfg_in.timer_clock_select_hi &
                      tmr_cfg_in.timer_clock_select_lo); // RULE_09
  assign div_last = (div_cnt_r == DIV_LAST);

  always_comb begin
    state_nxt = state_r;
    svc_nxt = 1'b0;
    fetch_nxt = 1'b0;
    wdg_rst_nxt = 1'b0;
    case (state_r)
      ST_RUN, ST_SLOW: begin
        if (wake_in.reset_req) begin
          fetch_nxt = 1'b1;
          state_nxt = ST_RUN; // RULE_22
        end else if (halt_exec) begin
          if (wdg_enabled_in && ctrl_r[PSMC_CTRL_WDGH_BIT]) begin
            wdg_rst_nxt = 1'b1; // RULE_19 RULE_23
          end else if (ahalt_sel) begin
            state_nxt = ST_AHALT; // RULE_09 RULE_15
          end else begin
            state_nxt = ST_HALT; // RULE_09 RULE_23
          end
        end else if (wait_instr_in) begin
          state_nxt = slow_sel ? ST_SLOW_WAIT : ST_WAIT; // RULE_03 RULE_05
        end else begin
          state_nxt = slow_sel ? ST_SLOW : ST_RUN; // RULE_02
        end
      end
      ST_WAIT, ST_SLOW_WAIT: begin
        if (wake_in.reset_req) begin
          fetch_nxt = 1'b1; // RULE_07
          state_nxt = ST_RUN;
        end else if (wake_in.irq_pending) begin
          svc_nxt = 1'b1; // RULE_07
          state_nxt = slow_sel ? ST_SLOW : ST_RUN;
        end
      end
      ST_AHALT: begin
        if (wake_in.reset_req) begin
          state_nxt = ST_STAB; // RULE_11
        end else if (wake_in.irq_timer_wake) begin
          svc_nxt = 1'b1; // RULE_10 RULE_12 RULE_13
          state_nxt = slow_sel ? ST_SLOW : ST_RUN;
        end
      end
      ST_HALT: begin
        if (wake_in.reset_req || wake_in.irq_halt_wake) begin
          state_nxt = ST_STAB; // RULE_17 RULE_18
        end
      end
      ST_STAB: begin
        if (stab_cnt_r == '0) begin
          if (stab_is_reset_r || wake_in.reset_req) begin
            fetch_nxt = 1'b1; // RULE_11 RULE_17
            state_nxt = ST_RUN;
          end else begin
            svc_nxt = 1'b1; // RULE_17
            state_nxt = slow_sel ? ST_SLOW : ST_RUN;
          end
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_RUN; // RULE_01 RULE_22
    end else begin
      state_r <= state_nxt;
    end
  end

  // stabilisation counter; the pll delay rides on top of the 256 cycles
  assign enter_stab = (state_nxt == ST_STAB) && (state_r != ST_STAB);
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stab_cnt_r <= '0;
      stab_len_r <= STAB_BASE;
      stab_is_reset_r <= 1'b0;
    end else if (enter_stab) begin
      stab_len_r <= ctrl_r[PSMC_CTRL_PLL_BIT] ? STAB_PLL : STAB_BASE;
      stab_cnt_r <= (ctrl_r[PSMC_CTRL_PLL_BIT] ? STAB_PLL : STAB_BASE)
                    - PSMC_CNT_W'(1); // RULE_17 RULE_20
      stab_is_reset_r <= wake_in.reset_req;
    end else if (state_r == ST_STAB) begin
      if (stab_cnt_r != '0) begin
        stab_cnt_r <= stab_cnt_r - PSMC_CNT_W'(1);
      end
      // a reset arriving mid-delay turns the exit into a reset fetch
      if (wake_in.reset_req) begin
        stab_is_reset_r <= 1'b1;
      end
    end
  end

  // divider only runs while the oscillator does
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_cnt_r <= '0;
    end else if (state_r != ST_HALT) begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  assign asleep_nxt = (state_nxt == ST_WAIT) ||
                      (state_nxt == ST_SLOW_WAIT) ||
                      (state_nxt == ST_AHALT) ||
                      (state_nxt == ST_HALT);
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      asleep_r <= 1'b0;
    end else begin
      asleep_r <= asleep_nxt;
    end
  end

  // clock enables, one cycle behind the state
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cpu_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      lite_timer_clk_en_out <= 1'b0;
      autoreload_timer_clk_en_out <= 1'b0;
      osc_en_out <= 1'b1;
      pll_clk_en_out <= 1'b0;
    end else begin
      cpu_clk_en_out <= (state_r == ST_RUN) ||
                        ((state_r == ST_SLOW) && div_last); // RULE_02
      periph_clk_en_out <= (state_r == ST_RUN) ||
                           (state_r == ST_WAIT) ||
                           (((state_r == ST_SLOW) ||
                             (state_r == ST_SLOW_WAIT)) &&
                            div_last); // RULE_03 RULE_05
      // lite timer ignores slow mode; in active-halt it runs only if chosen
      lite_timer_clk_en_out <= div_last &&
                               (state_r != ST_HALT) &&
                               (state_r != ST_STAB) &&
                               ((state_r != ST_AHALT) ||
                                tmr_cfg_in.timebase_irq_enable);
      // RULE_04 RULE_14
      autoreload_timer_clk_en_out <= (state_r == ST_RUN) ||
                                     (state_r == ST_WAIT) ||
                                     (((state_r == ST_SLOW) ||
                                       (state_r == ST_SLOW_WAIT)) &&
                                      div_last) ||
                                     ((state_r == ST_AHALT) &&
                                      !tmr_cfg_in.timebase_irq_enable);
      osc_en_out <= (state_r != ST_HALT); // RULE_16
      pll_clk_en_out <= ctrl_r[PSMC_CTRL_PLL_BIT] &&
                        (state_r != ST_HALT) &&
                        (state_r != ST_AHALT) &&
                        (state_r != ST_STAB); // RULE_20
    end
  end

  // event pulses towards the cpu core and reset logic
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      imask_clear_out <= 1'b0;
      irq_service_out <= 1'b0;
      reset_fetch_out <= 1'b0;
      wdg_reset_out <= 1'b0;
    end else begin
      imask_clear_out <= asleep_nxt && !asleep_r; // RULE_06 RULE_13 RULE_18
      // core pushes condition codes and sets the mask on this pulse
      irq_service_out <= svc_nxt; // RULE_08
      reset_fetch_out <= fetch_nxt;
      wdg_reset_out <= wdg_rst_nxt;
    end
  end

  // control register; a reset request also drops slow mode
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= PSMC_CTRL_RST;
    end else if (wake_in.reset_req) begin
      ctrl_r[PSMC_CTRL_SLOW_BIT] <= 1'b0; // RULE_01
    end else if (wr_en_in && (addr_in == PSMC_REG_CTRL)) begin
      ctrl_r <= wr_data_in[2:0];
    end
  end

  always_comb begin
    case (state_r)
      ST_RUN: mode_code = PSMC_MODE_RUN;
      ST_SLOW: mode_code = PSMC_MODE_SLOW;
      ST_WAIT: mode_code = PSMC_MODE_WAIT;
      ST_SLOW_WAIT: mode_code = PSMC_MODE_SLOW_WAIT;
      ST_AHALT: mode_code = PSMC_MODE_AHALT;
      ST_HALT: mode_code = PSMC_MODE_HALT;
      ST_STAB: mode_code = PSMC_MODE_STAB;
      default: mode_code = PSMC_MODE_RUN;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data_r <= 8'h00;
    end else if (rd_en_in && (addr_in == PSMC_REG_CTRL)) begin
      rd_data_r <= {5'h00, ctrl_r};
    end else if (rd_en_in && (addr_in == PSMC_REG_STATUS)) begin
      rd_data_r <= {3'h0, wdg_enabled_in, ahalt_sel, mode_code};
    end else begin
      rd_data_r <= 8'h00;
    end
  end
  assign rd_data_out = rd_data_r;

  // ---------------- checks ----------------
  logic [PSMC_CNT_W-1:0] chk_stab_r;
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chk_stab_r <= '0;
    end else if (state_r == ST_STAB) begin
      chk_stab_r <= chk_stab_r + PSMC_CNT_W'(1);
    end else begin
      chk_stab_r <= '0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_r);

  a_reset_to_run: assert property ( // RULE_01
    $rose(rst_n_r) |-> state_r == ST_RUN)
    else $error("not in run after reset");
  a_lite_div_rate: assert property ( // RULE_04
    lite_timer_clk_en_out |=> !lite_timer_clk_en_out [*8])
    else $error("lite timer enable faster than divider");
  a_wait_cpu_stop: assert property ( // RULE_05
    state_r == ST_WAIT |=> !cpu_clk_en_out && periph_clk_en_out)
    else $error("wait clocks wrong");
  a_mask_clear_entry: assert property ( // RULE_06
    (state_r == ST_RUN && wait_instr_in && !halt_exec &&
     !wake_in.reset_req) |=> imask_clear_out && state_r == ST_WAIT)
    else $error("wait entry did not clear mask");
  a_halt_select_ah: assert property ( // RULE_09
    (state_r == ST_RUN && halt_exec && ahalt_sel &&
     !wake_in.reset_req && !wdg_enabled_in) |=> state_r == ST_AHALT)
    else $error("active-halt not selected");
  a_ahalt_only_timer: assert property ( // RULE_10
    (state_r == ST_AHALT && !wake_in.irq_timer_wake &&
     !wake_in.reset_req) |=> state_r == ST_AHALT)
    else $error("active-halt left without timer wake");
  a_ahalt_irq_now: assert property ( // RULE_12
    (state_r == ST_AHALT && wake_in.irq_timer_wake &&
     !wake_in.reset_req) |=> irq_service_out && !osc_en_out == 1'b0)
    else $error("active-halt irq not serviced at once");
  a_halt_osc_off: assert property ( // RULE_16
    state_r == ST_HALT |=> !osc_en_out && !periph_clk_en_out &&
                          !cpu_clk_en_out)
    else $error("halt left clocks running");
  a_stab_length: assert property ( // RULE_17
    (state_r == ST_STAB && state_nxt != ST_STAB) |->
      chk_stab_r + PSMC_CNT_W'(1) == stab_len_r)
    else $error("stabilisation delay wrong length");
  a_wdg_halt_reset: assert property ( // RULE_19
    (state_r == ST_RUN && halt_exec && wdg_enabled_in &&
     ctrl_r[PSMC_CTRL_WDGH_BIT] && !wake_in.reset_req) |=>
      wdg_reset_out && state_r == ST_RUN)
    else $error("watchdog halt reset missing");

  c_slow_wait: cover property (state_r == ST_SLOW_WAIT);
  c_ahalt_wake: cover property (state_r == ST_AHALT ##1 irq_service_out);
  c_halt_stab: cover property (state_r == ST_HALT ##1 state_r == ST_STAB);
  c_wdg_reset: cover property (wdg_reset_out);

endmodule

// *** dv/psmc_core_model.sv ***
// behavioural cpu core and wake request latch model on the controller's far side
`timescale 1ns/10ps
module psmc_core_model
  import psmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic halt_req_in,
  input wire logic wait_req_in,
  input wire psmc_wake_s wake_set_in,
  input wire logic irq_service_in,
  input wire logic reset_fetch_in,
  output logic opcode_valid_out,
  output logic [7:0] opcode_out,
  output logic wait_exec_out,
  output psmc_wake_s wake_out
);
  logic [6:0] fill_r = 7'h00;
  logic [3:0] clr;

  // reset request is a one-cycle event, so the fetch cannot repeat;
  // interrupt requests stay latched until a service or reset fetch pulse
  assign clr = {{3{irq_service_in | reset_fetch_in}}, 1'b1};

  initial begin
    opcode_valid_out = 1'b0;
    opcode_out = 8'h01;
    wait_exec_out = 1'b0;
    wake_out = '0;
  end

  always @(posedge clk_in) begin
    fill_r <= fill_r + 7'h01;
    opcode_valid_out <= halt_req_in;
    // idle opcode bus keeps moving and is odd, so never the halt code
    opcode_out <= halt_req_in ? PSMC_HALT_OPCODE : {fill_r, 1'b1};
    wait_exec_out <= wait_req_in;
    // vector fetch acknowledges the latched requests
    wake_out <= (wake_out & ~clr) | wake_set_in;
  end
endmodule

// *** dv/tb_psmc_ctrl.sv ***
// self-checking testbench for the power saving mode controller
`timescale 1ns/10ps
module tb_psmc_ctrl;
  import psmc_pkg::*;
  localparam int PLL_N = 4;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic halt_req = 1'b0;
  logic wait_req = 1'b0;
  logic wdg_en = 1'b0;
  psmc_wake_s wake_set = '0;
  psmc_tmr_cfg_s tmr_cfg = '0;
  psmc_wake_s wake;
  logic [7:0] rd_data, op;
  logic op_v, wait_x, cpu_en, per_en, lite_en, arl_en, osc_en, pll_en;
  logic imask, svc, rfetch, wrst;
  logic rd_seen = 1'b0;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ev_cyc = 0;
  int n[5] = '{0, 0, 0, 0, 0};
  logic [7:0] rd_q[$];
  logic [2:0] ev_q[$];
  logic [31:0] seed = 32'hf8f37f98;

  psmc_ctrl #(.PLL_STAB_CYCLES(PLL_N)) u_dut (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .opcode_valid_in(op_v), .opcode_in(op), .wait_instr_in(wait_x),
    .tmr_cfg_in(tmr_cfg), .wake_in(wake), .wdg_enabled_in(wdg_en),
    .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
    .lite_timer_clk_en_out(lite_en), .autoreload_timer_clk_en_out(arl_en),
    .osc_en_out(osc_en), .pll_clk_en_out(pll_en), .imask_clear_out(imask),
    .irq_service_out(svc), .reset_fetch_out(rfetch), .wdg_reset_out(wrst));

  psmc_core_model u_core (.clk_in(clk_in), .halt_req_in(halt_req),
    .wait_req_in(wait_req), .wake_set_in(wake_set), .irq_service_in(svc),
    .reset_fetch_in(rfetch), .opcode_valid_out(op_v), .opcode_out(op),
    .wait_exec_out(wait_x), .wake_out(wake));

  always #20 clk_in = ~clk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] st(input logic [2:0] m, input logic ah);
    return {3'h0, wdg_en, ah, m};
  endfunction

  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_v(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ev(input logic [2:0] exp, input logic [2:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] event svc_rst_wdg expected %b seen %b", exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk_in);
    rd_en <= 1'b0;
  endtask

  task automatic wake_go(input psmc_wake_s w);
    @(posedge clk_in);
    wake_set <= w;
    @(posedge clk_in);
    wake_set <= '0;
  endtask

  // kind 1 is the wait instruction, 0 the halt opcode
  task automatic pulse(input logic kind);
    @(posedge clk_in);
    halt_req <= ~kind;
    wait_req <= kind;
    @(posedge clk_in);
    halt_req <= 1'b0;
    wait_req <= 1'b0;
  endtask

  // sleep entry must be marked by exactly one mask-clear pulse
  task automatic enter(input logic kind);
    int c0;
    c0 = n[4];
    pulse(kind);
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    chk_v("mask clear pulses", 8'h01, 8'(n[4] - c0));
  endtask

  task automatic wait_ev(input logic [2:0] kind, input int lo, input int hi);
    int t0;
    t0 = cyc;
    ev_q.push_back(kind);
    repeat (hi + 4) if (ev_q.size() != 0) @(posedge clk_in);
    @(negedge clk_in);
    chk_v("event latency ok", 8'h01, 8'((ev_q.size() == 0) &&
          (ev_cyc - t0 >= lo) && (ev_cyc - t0 <= hi)));
    @(posedge clk_in);
  endtask

  task automatic cnt64(input int k, input logic [7:0] exp);
    int c0;
    // let a mode change reach the enables, then count whole cycles only
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    c0 = n[k];
    repeat (64) @(posedge clk_in);
    @(negedge clk_in);
    chk_v("enable pulses in 64 cycles", exp, 8'(n[k] - c0));
  endtask

  task automatic lv(input logic [3:0] exp);
    @(negedge clk_in);
    chk_v("cpu_per_osc_pll", {4'h0, exp},
          {4'h0, cpu_en, per_en, osc_en, pll_en});
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    n[0] <= n[0] + int'(cpu_en);
    n[1] <= n[1] + int'(per_en);
    n[2] <= n[2] + int'(lite_en);
    n[3] <= n[3] + int'(arl_en);
    n[4] <= n[4] + int'(imask);
    rd_seen <= rd_en;
    if (rd_seen)
      chk_v("read data", rd_q.size() ? rd_q.pop_front() : 8'h00, rd_data);
    if ((svc | rfetch | wrst) === 1'b1) begin
      ev_cyc <= cyc;
      chk_ev(ev_q.size() ? ev_q.pop_front() : 3'h0, {svc, rfetch, wrst});
    end
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_RUN, 1'b0));
    rd(PSMC_REG_CTRL, 8'h00);
    seed = lfsr(seed);
    rd({seed[7:4] | 4'h1, seed[3:0]}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in);
      tmr_cfg <= 4'(i);
      rd(PSMC_REG_STATUS,
         st(PSMC_MODE_RUN, i[3] | (i[2] & ~i[1] & i[0])));
    end
    seed = lfsr(seed);
    wr(PSMC_REG_CTRL, {seed[7:3], 3'h1});
    rd(PSMC_REG_CTRL, 8'h01);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_SLOW, 1'b1));
    cnt64(0, 8'h02);
    cnt64(2, 8'h02);
    enter(1'b1);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_SLOW_WAIT, 1'b1));
    cnt64(1, 8'h02);
    wake_go(4'b1000);
    wait_ev(3'b100, 0, 8);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_SLOW, 1'b1));
    wr(PSMC_REG_CTRL, 8'h00);
    cnt64(0, 8'h40);
    cnt64(2, 8'h02);
    enter(1'b1);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_WAIT, 1'b1));
    lv(4'b0110);
    wake_go(4'b1000);
    wait_ev(3'b100, 0, 8);
    tmr_cfg <= 4'h0;
    enter(1'b0);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_HALT, 1'b0));
    lv(4'b0000);
    wake_go(4'b1010);
    repeat (20) @(posedge clk_in);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_HALT, 1'b0));
    wake_go(4'b0100);
    wait_ev(3'b100, 255, 264);
    tmr_cfg <= 4'b1000;
    enter(1'b0);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_AHALT, 1'b1));
    cnt64(2, 8'h02);
    cnt64(1, 8'h00);
    wake_go(4'b1100);
    repeat (20) @(posedge clk_in);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_AHALT, 1'b1));
    wake_go(4'b0010);
    wait_ev(3'b100, 0, 6);
    tmr_cfg <= 4'b0101;
    enter(1'b0);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_AHALT, 1'b1));
    cnt64(3, 8'h40);
    wake_go(4'b0001);
    wait_ev(3'b010, 255, 264);
    wake_go(4'b0010);
    pulse(1'b0);
    wait_ev(3'b100, 0, 8);
    wdg_en <= 1'b1;
    tmr_cfg <= 4'h0;
    wr(PSMC_REG_CTRL, 8'h02);
    pulse(1'b0);
    wait_ev(3'b001, 0, 6);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_RUN, 1'b0));
    tmr_cfg <= 4'b1000;
    wr(PSMC_REG_CTRL, 8'h00);
    enter(1'b0);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_AHALT, 1'b1));
    wake_go(4'b0010);
    wait_ev(3'b100, 0, 6);
    wdg_en <= 1'b0;
    tmr_cfg <= 4'h0;
    wr(PSMC_REG_CTRL, 8'h04);
    repeat (4) @(posedge clk_in);
    lv(4'b1111);
    enter(1'b0);
    lv(4'b0000);
    wake_go(4'b0100);
    wait_ev(3'b100, 255 + PLL_N, 264 + PLL_N);
    wr(PSMC_REG_CTRL, 8'h01);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(PSMC_REG_STATUS, st(PSMC_MODE_RUN, 1'b0));
    rd(PSMC_REG_CTRL, 8'h00);
    repeat (3) @(posedge clk_in);
    final_report();
  end
endmodule
